// *** core/cfsup_top.sv ***
`timescale 1ns/1ps
module cfsup_top #(
  parameter int unsigned UV_CYCLES = cfsup_pkg::UV_CYC,
  parameter int unsigned OFF_CYCLES = cfsup_pkg::OFF_CYC,
  parameter int unsigned ON_CYCLES = cfsup_pkg::ON_CYC,
  parameter int unsigned REV_CYCLES = cfsup_pkg::REV_CYC,
  parameter longint unsigned WIN_CYCLES = cfsup_pkg::WIN_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // analog comparators (asynchronous)
  input wire logic guard_trip_in,
  input wire logic guard_clear_in,
  input wire logic gate_bad_in,
  input wire logic sys_uv_in,
  input wire logic bus_high_in,
  input wire logic rev_ov_in,
  input wire logic rev_uv_in,
  input wire logic overtemp_in,
  input wire logic battery_switch_on,
  // analog measured values and pin strap
  input wire logic [15:0] battery_mv,
  input wire logic [2:0] cell_count_pin,
  // host controls
  input wire logic near_full_duty_wr,
  input wire logic near_full_duty_wdata,
  input wire logic sys_uv_disable,
  input wire logic sys_uv_retry_off,
  input wire logic [15:0] uv_threshold_wr_mv,
  input wire logic uv_threshold_wr,
  input wire logic sys_short_clear_wr,
  input wire logic reverse_enable_wr,
  input wire logic reverse_enable_wdata,
  input wire logic reverse_fault_on_pgood,
  input wire logic min_sys_wr,
  input wire logic [15:0] min_sys_wdata,
  input wire logic [1:0] min_sys_ramp_select,
  input wire logic [15:0] target_charge_amps,
  input wire logic charge_block,
  // host status reads (one-cycle strobes)
  input wire logic gate_flag_rd,
  input wire logic rev_ov_flag_rd,
  input wire logic rev_uv_flag_rd,
  input wire logic overtemp_rd,
  // status and control out
  output logic near_full_duty_mode_en,
  output logic guard_blocked,
  output logic gate_supply_fault_flag,
  output logic sys_short_fault_flag,
  output logic reverse_power_enable,
  output logic reverse_over_voltage_flag,
  output logic reverse_under_voltage_flag,
  output logic overtemp_shutdown,
  output logic power_good_out,
  output logic converter_on,
  output logic soft_start,
  output logic gate_supply_limit,
  output logic bus_sink_en,
  output logic [15:0] input_current_cap,
  output logic [15:0] uv_threshold_mv,
  output logic [15:0] min_sys_target,
  output logic [15:0] sys_reg_target,
  output logic [15:0] target_pack_voltage,
  output logic charging_en
);
  import cfsup_pkg::*;

  // elaboration check
  if (UV_CYCLES < 1 || OFF_CYCLES < 1 || ON_CYCLES < 1 ||
      REV_CYCLES < 1 || WIN_CYCLES < 1) begin : g_bad
    $error("cfsup_top: cycle counts must be at least one");
  end

  // synchronizer stages for comparator inputs
  localparam int NS = 9;
  logic [NS-1:0] meta;
  logic [NS-1:0] sync;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta <= '0;
      sync <= '0;
    end else begin
      meta <= {battery_switch_on, overtemp_in, rev_uv_in, rev_ov_in,
               bus_high_in, sys_uv_in, gate_bad_in, guard_clear_in,
               guard_trip_in};
      sync <= meta;
    end
  end
  logic g_trip, g_clr, gate_bad, uv_pin, bus_hi, r_ov, r_uv, hot, bsw;
  logic uv_raw;
  assign {bsw, hot, r_uv, r_ov, bus_hi, uv_pin, gate_bad, g_clr,
          g_trip} = sync;
  assign uv_raw = uv_pin && !sys_uv_disable;
  // deglitch counters: restart whenever the condition drops
  function automatic logic [31:0] dg_next(input logic cond,
      input logic [31:0] cnt, input logic [31:0] lim);
    if (!cond) dg_next = '0;
    else if (cnt < lim) dg_next = cnt + 32'h1;
    else dg_next = cnt;
  endfunction : dg_next

  logic [31:0] trip_cnt, clr_cnt, gbad_cnt, gok_cnt, uv_cnt, ov_cnt, un_cnt;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      trip_cnt <= '0;
      clr_cnt <= '0;
      gbad_cnt <= '0;
      gok_cnt <= '0;
      uv_cnt <= '0;
      ov_cnt <= '0;
      un_cnt <= '0;
    end else begin
      trip_cnt <= dg_next(g_trip, trip_cnt, 32'(GUARD_CYC));
      clr_cnt <= dg_next(g_clr, clr_cnt, 32'(GUARD_CYC));
      gbad_cnt <= dg_next(gate_bad, gbad_cnt, 32'(GATE_CYC));
      gok_cnt <= dg_next(!gate_bad, gok_cnt, 32'(GATE_CYC));
      uv_cnt <= dg_next(uv_raw, uv_cnt, 32'(UV_CYCLES));
      ov_cnt <= dg_next(r_ov && reverse_power_enable, ov_cnt,
                        32'(REV_CYCLES));
      un_cnt <= dg_next(r_uv && reverse_power_enable, un_cnt,
                        32'(REV_CYCLES));
    end
  end
  logic trip_hit, clr_hit, gbad_hit, gok_hit, uv_hit, ov_hit, un_hit;
  assign trip_hit = trip_cnt == 32'(GUARD_CYC);
  assign clr_hit = clr_cnt == 32'(GUARD_CYC);
  assign gbad_hit = gbad_cnt == 32'(GATE_CYC);
  assign gok_hit = gok_cnt == 32'(GATE_CYC);
  assign uv_hit = uv_cnt == 32'(UV_CYCLES);
  assign ov_hit = ov_cnt == 32'(REV_CYCLES);
  assign un_hit = un_cnt == 32'(REV_CYCLES);

  // reverse boost guard and near-full-duty bit
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      guard_blocked <= 1'b0;
      near_full_duty_mode_en <= 1'b0;
    end else begin
      if (trip_hit) begin
        guard_blocked <= 1'b1;
      end else if (clr_hit) begin
        guard_blocked <= 1'b0;
      end
      if (trip_hit && near_full_duty_mode_en) begin
        near_full_duty_mode_en <= 1'b0;
      end else if (near_full_duty_wr) begin
        // refuse setting while tripped
        near_full_duty_mode_en <= near_full_duty_wdata &&
                                  !guard_blocked && !trip_hit;
      end
    end
  end

  // gate drive supply fault handling
  logic gate_down;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      gate_down <= 1'b0;
      gate_supply_fault_flag <= 1'b0;
    end else begin
      if (gbad_hit) begin
        gate_down <= 1'b1;
      end else if (gok_hit) begin
        gate_down <= 1'b0;
      end
      if (gbad_hit) begin
        gate_supply_fault_flag <= 1'b1;
      end else if (gate_flag_rd && !gate_bad && !gate_down) begin
        gate_supply_fault_flag <= 1'b0;
      end
    end
  end

  // undervoltage threshold register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      uv_threshold_mv <= UV_RESET_MV;
    end else if (uv_threshold_wr) begin
      uv_threshold_mv <= uv_threshold_wr_mv;
    end
  end

  // undervoltage retry machine
  cfsup_uv_t uv_state;
  logic [31:0] uv_tmr;
  logic [2:0] fails;
  logic [39:0] win_tmr;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      uv_state <= CFSUP_RUN;
      uv_tmr <= '0;
      fails <= '0;
      win_tmr <= '0;
      sys_short_fault_flag <= 1'b0;
    end else begin
      // failure window restarts the count when it expires
      if (fails != 3'h0 && win_tmr < 40'(WIN_CYCLES)) begin
        win_tmr <= win_tmr + 40'h1;
      end else if (fails != 3'h0) begin
        fails <= '0;
        win_tmr <= '0;
      end
      case (uv_state)
        CFSUP_RUN: begin
          if (uv_hit && sys_uv_retry_off) begin
            uv_state <= CFSUP_LATCH;
            sys_short_fault_flag <= 1'b1;
          end else if (uv_hit) begin
            uv_state <= CFSUP_OFF;
            uv_tmr <= '0;
          end
        end
        CFSUP_OFF: begin
          if (uv_tmr + 32'h1 >= 32'(OFF_CYCLES)) begin
            uv_state <= CFSUP_TRY;
            uv_tmr <= '0;
          end else begin
            uv_tmr <= uv_tmr + 32'h1;
          end
        end
        CFSUP_TRY: begin
          if (uv_tmr + 32'h1 >= 32'(ON_CYCLES)) begin
            uv_tmr <= '0;
            if (!uv_raw) begin
              uv_state <= CFSUP_RUN;
            end else if (32'(fails) + 32'h1 >= 32'(RETRY_MAX)) begin
              uv_state <= CFSUP_LATCH;
              sys_short_fault_flag <= 1'b1;
              fails <= '0;
              win_tmr <= '0;
            end else begin
              uv_state <= CFSUP_OFF;
              fails <= fails + 3'h1;
              if (fails == 3'h0) begin
                win_tmr <= '0;
              end
            end
          end else begin
            uv_tmr <= uv_tmr + 32'h1;
          end
        end
        CFSUP_LATCH: begin
          if (sys_short_clear_wr) begin
            uv_state <= CFSUP_RUN;
            sys_short_fault_flag <= 1'b0;
          end
        end
        default: uv_state <= CFSUP_RUN;
      endcase
    end
  end

  // reverse mode enable and fault flags
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reverse_power_enable <= 1'b0;
      reverse_over_voltage_flag <= 1'b0;
      reverse_under_voltage_flag <= 1'b0;
      bus_sink_en <= 1'b0;
    end else begin
      bus_sink_en <= reverse_power_enable && r_ov;
      if (ov_hit || un_hit) begin
        reverse_power_enable <= 1'b0;
      end else if (reverse_enable_wr) begin
        reverse_power_enable <= reverse_enable_wdata;
      end
      if (ov_hit) begin
        reverse_over_voltage_flag <= 1'b1;
      end else if (rev_ov_flag_rd) begin
        reverse_over_voltage_flag <= 1'b0;
      end
      if (un_hit) begin
        reverse_under_voltage_flag <= 1'b1;
      end else if (rev_uv_flag_rd) begin
        reverse_under_voltage_flag <= 1'b0;
      end
    end
  end

  // thermal shutdown status and recovery soft start
  logic hot_d;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      overtemp_shutdown <= 1'b0;
      gate_supply_limit <= 1'b0;
      soft_start <= 1'b0;
      hot_d <= 1'b0;
    end else begin
      hot_d <= hot;
      gate_supply_limit <= hot;
      soft_start <= hot_d && !hot;
      if (hot) begin
        overtemp_shutdown <= 1'b1;
      end else if (overtemp_rd) begin
        overtemp_shutdown <= 1'b0;
      end
    end
  end

  // converter run, power good and current cap
  logic rev_pg_fault;
  assign rev_pg_fault = reverse_fault_on_pgood &&
                        (reverse_over_voltage_flag ||
                         reverse_under_voltage_flag);
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      converter_on <= 1'b0;
      power_good_out <= 1'b0;
      input_current_cap <= 16'hffff;
    end else begin
      converter_on <= !gate_down && !hot && uv_state != CFSUP_OFF &&
                      uv_state != CFSUP_LATCH;
      power_good_out <= !gate_down && uv_state != CFSUP_LATCH &&
                        !rev_pg_fault;
      input_current_cap <= !uv_raw ? 16'hffff :
                           bus_hi ? CAP_HIGH_MA : CAP_LOW_MA;
    end
  end

  // minimum system voltage soft ramp, target in mV times 64
  logic [21:0] ramp_acc;
  logic [21:0] ramp_goal;
  logic [7:0] us_cnt;
  logic [15:0] step;
  always_comb begin
    case (min_sys_ramp_select)
      2'h1: step = RAMP_FAST;
      2'h2: step = RAMP_MID;
      2'h3: step = RAMP_SLOW;
      default: step = 16'h0;
    endcase
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ramp_acc <= '0;
      ramp_goal <= '0;
      us_cnt <= '0;
    end else begin
      us_cnt <= (us_cnt + 8'h1 >= 8'(US_CYC)) ? 8'h0 : us_cnt + 8'h1;
      if (min_sys_wr) begin
        ramp_goal <= {min_sys_wdata, 6'h0};
        if ({min_sys_wdata, 6'h0} < ramp_acc || step == 16'h0) begin
          ramp_acc <= {min_sys_wdata, 6'h0};
        end
      end else if (us_cnt == 8'h0 && ramp_acc < ramp_goal) begin
        ramp_acc <= (ramp_goal - ramp_acc > 22'(step)) ?
                    ramp_acc + 22'(step) : ramp_goal;
      end
    end
  end
  assign min_sys_target = ramp_acc[21:6];

  // system regulation target and charge voltage
  logic [15:0] above_bat;
  assign above_bat = battery_mv + SYS_ABOVE_MV;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sys_reg_target <= '0;
      target_pack_voltage <= '0;
      charging_en <= 1'b0;
    end else begin
      sys_reg_target <= (!bsw && above_bat > min_sys_target) ?
                        above_bat : min_sys_target;
      target_pack_voltage <= 16'(CELL_MV * cell_count_pin);
      charging_en <= !charge_block && target_charge_amps != 16'h0;
    end
  end
endmodule : cfsup_top

// *** core/cfsup_pkg.sv ***
package cfsup_pkg;
  // clock rate
  localparam int unsigned CLK_HZ = 100_000_000;
  // deglitch and retry times
  localparam int unsigned GUARD_US = 15;
  localparam int unsigned GATE_US = 100;
  localparam int unsigned UV_MS = 2;
  localparam int unsigned OFF_MS = 500;
  localparam int unsigned ON_MS = 10;
  localparam int unsigned REV_MS = 10;
  localparam int unsigned WIN_S = 90;
  localparam int unsigned GUARD_CYC = GUARD_US * (CLK_HZ / 1_000_000);
  localparam int unsigned GATE_CYC = GATE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned UV_CYC = UV_MS * (CLK_HZ / 1000);
  localparam int unsigned OFF_CYC = OFF_MS * (CLK_HZ / 1000);
  localparam int unsigned ON_CYC = ON_MS * (CLK_HZ / 1000);
  localparam int unsigned REV_CYC = REV_MS * (CLK_HZ / 1000);
  localparam longint unsigned WIN_CYC = longint'(WIN_S) * CLK_HZ;
  localparam int unsigned RETRY_MAX = 7;
  // voltages in millivolts, currents in milliamps
  localparam logic [15:0] UV_RESET_MV = 16'h0960; // 2400 mV
  localparam logic [15:0] BUS_SPLIT_MV = 16'h3840; // 14400 mV
  localparam logic [15:0] CAP_LOW_MA = 16'h01f4; // 500 mA
  localparam logic [15:0] CAP_HIGH_MA = 16'h012c; // 300 mA
  localparam logic [15:0] SYS_ABOVE_MV = 16'h0096; // 150 mV
  localparam logic [15:0] CELL_MV = 16'h1068; // 4200 mV
  // ramp steps in millivolts per microsecond times 64
  localparam logic [15:0] RAMP_FAST = 16'h0190; // 6.25
  localparam logic [15:0] RAMP_MID = 16'h00c8; // 3.125
  localparam logic [15:0] RAMP_SLOW = 16'h0064; // 1.5625
  localparam int unsigned US_CYC = CLK_HZ / 1_000_000;
  // undervoltage retry states
  typedef enum logic [1:0] {CFSUP_RUN, CFSUP_OFF, CFSUP_TRY, CFSUP_LATCH}
    cfsup_uv_t;
endpackage : cfsup_pkg

// *** verif/cfsup_stage_model.sv ***
`timescale 1ns/1ps
module cfsup_stage_model #(
  // reverse bus fault levels, plain defaults
  parameter logic [15:0] REV_OV_MV = 16'h7530,
  parameter logic [15:0] REV_UV_MV = 16'h0fa0
) (
  // rails in mV
  input wire logic [15:0] sys_mv,
  input wire logic [15:0] bus_mv,
  input wire logic [15:0] uv_threshold_mv,
  // comparator levels
  output logic guard_trip_in,
  output logic guard_clear_in,
  output logic sys_uv_in,
  output logic bus_high_in,
  output logic rev_ov_in,
  output logic rev_uv_in
);
  import cfsup_pkg::*;
  // 97.5 percent as sys*40 against bus*39
  assign guard_trip_in = 32'(sys_mv) * 40 > 32'(bus_mv) * 39;
  // 80 mV hysteresis, scaled by 40
  assign guard_clear_in =
    32'(sys_mv) * 40 + 3200 < 32'(bus_mv) * 39;
  assign sys_uv_in = sys_mv < uv_threshold_mv;
  assign bus_high_in = bus_mv > BUS_SPLIT_MV;
  // reverse bus levels
  assign rev_ov_in = bus_mv > REV_OV_MV;
  assign rev_uv_in = bus_mv < REV_UV_MV;
endmodule : cfsup_stage_model

// *** verif/cfsup_props.sv ***
`timescale 1ns/1ps
module cfsup_props (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // host side
  input wire logic near_full_duty_wr,
  input wire logic sys_short_clear_wr,
  input wire logic overtemp_rd,
  input wire logic min_sys_wr,
  input wire logic [15:0] min_sys_wdata,
  input wire logic [1:0] min_sys_ramp_select,
  // supervisor outputs
  input wire logic near_full_duty_mode_en,
  input wire logic guard_blocked,
  input wire logic gate_supply_fault_flag,
  input wire logic sys_short_fault_flag,
  input wire logic reverse_power_enable,
  input wire logic reverse_over_voltage_flag,
  input wire logic reverse_under_voltage_flag,
  input wire logic overtemp_shutdown,
  input wire logic power_good_out,
  input wire logic converter_on,
  input wire logic [15:0] min_sys_target
);
  // single clock domain
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  nfd_refuse_a: assert property (
    guard_blocked && near_full_duty_wr |=> !near_full_duty_mode_en)
    else $error("entry while blocked");
  nfd_force_a: assert property (
    $rose(guard_blocked) |-> ##[0:1] !near_full_duty_mode_en)
    else $error("not forced off");
  gate_stop_a: assert property (
    $rose(gate_supply_fault_flag) |=> !converter_on && !power_good_out)
    else $error("gate fault kept running");
  short_off_a: assert property (
    sys_short_fault_flag [*2] |-> !converter_on && !power_good_out)
    else $error("latched yet running");
  short_hold_a: assert property (
    sys_short_fault_flag && !sys_short_clear_wr |=> sys_short_fault_flag)
    else $error("latch left alone");
  ot_hold_a: assert property (
    overtemp_shutdown && !overtemp_rd |=> overtemp_shutdown)
    else $error("overtemp bit lost");
  rev_exit_a: assert property (
    $rose(reverse_over_voltage_flag) || $rose(reverse_under_voltage_flag)
    |-> ##[0:1] !reverse_power_enable)
    else $error("reverse kept on");
  ramp_step_a: assert property (
    min_sys_wr && (min_sys_ramp_select == 2'h0 ||
    min_sys_wdata < min_sys_target) |=> min_sys_target == $past(min_sys_wdata))
    else $error("target not immediate");
  ramp_slow_a: assert property (
    min_sys_wr && min_sys_ramp_select != 2'h0 &&
    min_sys_wdata > min_sys_target + 16'h0007 |=>
    min_sys_target != $past(min_sys_wdata))
    else $error("upward step not ramped");
endmodule : cfsup_props
bind cfsup_top cfsup_props i_props (.*);

// *** verif/cfsup_tb.sv ***
`timescale 1ns/1ps
module testbench;
  import cfsup_pkg::*;
  // bench levels
  logic clk, reset, gate_bad_in, overtemp_in, battery_switch_on;
  logic sys_uv_disable, sys_uv_retry_off, reverse_fault_on_pgood;
  logic charge_block, guard_trip_in, guard_clear_in, sys_uv_in;
  logic bus_high_in, rev_ov_in, rev_uv_in, soft_start, bus_sink_en;
  logic near_full_duty_mode_en, guard_blocked, gate_supply_fault_flag;
  logic sys_short_fault_flag, reverse_power_enable, charging_en;
  logic reverse_over_voltage_flag, reverse_under_voltage_flag;
  logic overtemp_shutdown, power_good_out, converter_on, gate_supply_limit;
  logic [1:0] min_sys_ramp_select;
  logic [2:0] cell_count_pin;
  logic [8:0] stb;
  logic [15:0] battery_mv, target_charge_amps, sys_mv, bus_mv, wd;
  logic [15:0] input_current_cap, uv_threshold_mv, min_sys_target;
  logic [15:0] sys_reg_target, target_pack_voltage;
  // host strobes share one write data word
  wire near_full_duty_wr = stb[0];
  wire uv_threshold_wr = stb[1];
  wire sys_short_clear_wr = stb[2];
  wire reverse_enable_wr = stb[3];
  wire min_sys_wr = stb[4];
  wire gate_flag_rd = stb[5];
  wire rev_ov_flag_rd = stb[6];
  wire rev_uv_flag_rd = stb[7];
  wire overtemp_rd = stb[8];
  wire near_full_duty_wdata = wd[0];
  wire reverse_enable_wdata = wd[0];
  wire [15:0] uv_threshold_wr_mv = wd;
  wire [15:0] min_sys_wdata = wd;
  int mismatches, n_checks, cyc;
  cfsup_top #(.UV_CYCLES(20), .OFF_CYCLES(50), .ON_CYCLES(10),
    .REV_CYCLES(20), .WIN_CYCLES(100000)) i_dut (.*);
  cfsup_stage_model i_stage (.*);
  always #5 clk = ~clk;
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      mismatches++;
      end_sim();
    end
  end
  task end_sim;
    if (mismatches == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // settle after n edges
  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  // one host strobe with data, then one edge for the answer
  task pulse(input int b, input logic [15:0] d);
    @(posedge clk);
    stb[b] <= 1'b1;
    wd <= d;
    @(posedge clk);
    stb[b] <= 1'b0;
    step(1);
  endtask : pulse
  initial begin
    {clk, gate_bad_in, overtemp_in, sys_uv_disable, sys_uv_retry_off,
      reverse_fault_on_pgood, charge_block, min_sys_ramp_select, stb} = '0;
    {reset, battery_switch_on} = 2'h3;
    cell_count_pin = 3'h4;
    battery_mv = 16'h3000;
    target_charge_amps = 16'h03e8;
    sys_mv = 16'h2ee0;
    bus_mv = 16'h4e20;
    wd = 16'h0;
    step(7);
    chk("cap", 16'hffff, input_current_cap);
    chk("uvthr", UV_RESET_MV, uv_threshold_mv);
    @(posedge clk) reset <= 1'b0;
    step(3);
    chk("pack", 16'(CELL_MV * 4), target_pack_voltage);
    // near-full-duty: glitch, trip, refuse, hysteresis, release
    pulse(0, 16'h1);
    chk("nfd", 1, near_full_duty_mode_en);
    @(posedge clk) sys_mv <= 16'h4d58;
    step(1000);
    @(posedge clk) sys_mv <= 16'h2ee0;
    step(20);
    @(posedge clk) sys_mv <= 16'h4d58;
    step(1000);
    chk("glitch", 1, near_full_duty_mode_en);
    step(600);
    chk("trip", 0, near_full_duty_mode_en);
    pulse(0, 16'h1);
    chk("refuse", 0, near_full_duty_mode_en);
    @(posedge clk) sys_mv <= 16'h4bfa;
    step(1600);
    chk("hyst", 1, guard_blocked);
    @(posedge clk) sys_mv <= 16'h2ee0;
    step(1600);
    pulse(0, 16'h1);
    chk("rearm", 1, near_full_duty_mode_en);
    // gate supply fault and recovery
    @(posedge clk) gate_bad_in <= 1'b1;
    step(10010);
    chk("gflag", 1, gate_supply_fault_flag);
    chk("gpg", 0, power_good_out);
    pulse(5, 16'h0);
    chk("grd", 1, gate_supply_fault_flag);
    @(posedge clk) gate_bad_in <= 1'b0;
    step(10010);
    chk("gback", 1, converter_on);
    pulse(5, 16'h0);
    chk("gclr", 0, gate_supply_fault_flag);
    // overtemp, then the one-cycle soft start pulse on recovery
    @(posedge clk) overtemp_in <= 1'b1;
    step(6);
    chk("ot", 1, overtemp_shutdown);
    chk("otcv", 0, converter_on);
    chk("otlim", 1, gate_supply_limit);
    pulse(8, 16'h0);
    chk("otrd", 1, overtemp_shutdown);
    @(posedge clk) overtemp_in <= 1'b0;
    step(3);
    chk("soft", 1, soft_start);
    step(3);
    chk("otback", 1, converter_on);
    pulse(8, 16'h0);
    chk("otclr", 0, overtemp_shutdown);
    // reverse over- and undervoltage
    pulse(3, 16'h1);
    @(posedge clk) bus_mv <= 16'h7918;
    step(5);
    chk("sink", 1, bus_sink_en);
    step(30);
    chk("oven", 0, reverse_power_enable);
    chk("ovflag", 1, reverse_over_voltage_flag);
    chk("ovpg", 1, power_good_out);
    pulse(6, 16'h0);
    chk("ovclr", 0, reverse_over_voltage_flag);
    @(posedge clk) reverse_fault_on_pgood <= 1'b1;
    pulse(3, 16'h1);
    @(posedge clk) bus_mv <= 16'h0bb8;
    step(35);
    chk("uvflag", 1, reverse_under_voltage_flag);
    chk("uvpg", 0, power_good_out);
    pulse(7, 16'h0);
    chk("uvclr", 0, reverse_under_voltage_flag);
    @(posedge clk) bus_mv <= 16'h4e20;
    // min system voltage for ramp settings 1 to 3
    pulse(4, 16'h1000);
    for (int s = 1; s < 4; s++) begin
      @(posedge clk) min_sys_ramp_select <= 2'(s);
      pulse(4, 16'h1064);
      step(800 << (s - 1));
      chk("mid", 1, 16'(min_sys_target < 16'h1064));
      step(820 << (s - 1));
      chk("top", 16'h1064, min_sys_target);
      pulse(4, 16'h1000);
    end
    // charge stop by amps, then block; rail above battery
    chk("chg", 1, charging_en);
    @(posedge clk) target_charge_amps <= 16'h0;
    step(2);
    chk("amps", 0, charging_en);
    @(posedge clk) target_charge_amps <= 16'h03e8;
    charge_block <= 1'b1;
    step(2);
    chk("block", 0, charging_en);
    @(posedge clk) battery_switch_on <= 1'b0;
    step(5);
    chk("sysreg", battery_mv + SYS_ABOVE_MV, sys_reg_target);
    // undervoltage cap, retry, latch, clear
    @(posedge clk) sys_mv <= 16'h07d0;
    step(30);
    chk("caphi", CAP_HIGH_MA, input_current_cap);
    chk("uvoff", 0, converter_on);
    @(posedge clk) bus_mv <= 16'h2ee0;
    step(4);
    chk("caplo", CAP_LOW_MA, input_current_cap);
    step(600);
    chk("latch", 1, sys_short_fault_flag);
    @(posedge clk) sys_mv <= 16'h2ee0;
    step(50);
    chk("held", 0, converter_on);
    pulse(2, 16'h0);
    step(2);
    chk("clr", 0, sys_short_fault_flag);
    @(posedge clk) sys_uv_retry_off <= 1'b1;
    sys_mv <= 16'h07d0;
    step(30);
    chk("noretry", 1, sys_short_fault_flag);
    // let the deglitch count drain before the clear, or it relatches
    @(posedge clk) sys_mv <= 16'h2ee0;
    step(5);
    pulse(2, 16'h0);
    @(posedge clk) sys_uv_disable <= 1'b1;
    sys_mv <= 16'h07d0;
    step(600);
    chk("uvdis", 0, sys_short_fault_flag);
    pulse(1, 16'h0bb8);
    chk("thrwr", 16'h0bb8, uv_threshold_mv);
    end_sim();
  end
endmodule : testbench
